// ===== design/osc_map.svh
// Register map, reset values and timing constants of the output sequencer
// ==========================================================================
// Behaviour
// - Each channel keeps its own recorder on/off flag, readable as set.
// - Each channel keeps repeat mode: infinite, or a given repeat count.
// - With finish behaviour off, output disables once the whole sequence ends.
// - With finish behaviour last, output holds final group's voltage and current.
// - Groups per cycle is set per channel, 1 to 2048, readable back.
// - With a given repeat count, total steps are groups times repeats; stepping stops when all are done.
// - Each entry dwells 1 to 300 seconds before the next entry; the first entry after a start may end up to one second early.
// - Finish behaviour reads back as off or last.
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

// ==========================================================================
// Register offsets within a channel window
`define OSC_REG_CFG 3'h0
`define OSC_REG_REPEAT 3'h1
`define OSC_REG_GROUPS 3'h2
`define OSC_REG_INDEX 3'h3
`define OSC_REG_ENTRY_VI 3'h4
`define OSC_REG_ENTRY_T 3'h5
`define OSC_REG_STATUS 3'h6
`define OSC_CH_STRIDE_BIT 5

// ==========================================================================
// Field positions
`define OSC_CFG_REC_EN 0
`define OSC_CFG_FIN_LAST 1
`define OSC_CFG_REP_INF 2
`define OSC_CFG_START 3
`define OSC_CFG_STOP 4
`define OSC_ST_RUN 0
`define OSC_ST_DONE 1
`define OSC_ST_OUT_EN 2

// ==========================================================================
// Limits and reset values
`define OSC_GROUPS_MIN 12'h001
`define OSC_GROUPS_MAX 12'h800
`define OSC_GROUPS_RST 12'h001
`define OSC_REPEAT_RST 16'h0001
`define OSC_DWELL_MIN 9'h001
`define OSC_DWELL_MAX 9'h12C

// ==========================================================================
// Timing
`define OSC_CLK_HZ 125000000
`define OSC_TICK_S 1

`endif

// ===== design/osc_pkg.sv
// Types shared by the output sequencer and its users
package osc_pkg;

  // ========================================================================
  // Sequencer state
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_DONE
  } seq_e;

  // ========================================================================
  // Wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  // ========================================================================
  // Drive of one supply output
  typedef struct packed {
    logic out_en;
    logic rec_en;
    logic [15:0] volt;
    logic [15:0] curr;
  } supply_s;

  // ========================================================================
  // Per channel control and sequence state
  typedef struct packed {
    logic rec_en;
    logic fin_last;
    logic rep_inf;
    logic [15:0] rep_cnt;
    logic [11:0] groups;
    logic [10:0] idx_sel;
    logic [31:0] vi_stage;
    seq_e seq;
    logic out_en;
    logic [10:0] step;
    logic [15:0] cycle;
    logic [8:0] dwell;
    logic [15:0] volt;
    logic [15:0] curr;
  } chan_s;

  // ========================================================================
  // Whole module state
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [26:0] pre;
    chan_s [1:0] ch;
  } state_s;

endpackage

// ===== design/osc_top.sv
// Two channel output sequencer with Wishbone register access
`timescale 1ns/1ps
`include "osc_map.svh"

module osc_top #(
  parameter int unsigned P_SEC_REPEAT_COUNT = `OSC_CLK_HZ * `OSC_TICK_S
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Wishbone slave
  input osc_pkg::wb_req_s i_wb,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Supply drive, index 1 is second_output
  output osc_pkg::supply_s [1:0] o_supply
);

  // ========================================================================
  // Sequence table, plain flip-flops without reset
  logic [31:0] tbl_vi [2][2048];
  logic [8:0] tbl_t [2][2048];

  osc_pkg::state_s s_r;
  osc_pkg::state_s s_nxt;

  logic tbl_we;
  logic tbl_ch;
  logic [10:0] tbl_idx;
  logic [31:0] tbl_wvi;
  logic [8:0] tbl_wt;

  // ========================================================================
  // Table write port
  always_ff @(posedge i_clk) begin
    if (tbl_we) begin
      tbl_vi[tbl_ch][tbl_idx] <= tbl_wvi;
      tbl_t[tbl_ch][tbl_idx] <= tbl_wt;
    end
  end

  // ========================================================================
  // Next state
  always_comb begin
    logic acc;
    logic wr;
    logic chs;
    logic [2:0] rsel;
    logic [31:0] wd;
    logic [31:0] rd;
    logic tick;
    logic [10:0] nidx;
    logic [8:0] t;
    logic last;
    acc = 1'b0;
    wr = 1'b0;
    chs = 1'b0;
    rsel = 3'h0;
    wd = 32'h0;
    rd = 32'h0;
    tick = 1'b0;
    nidx = 11'h0;
    t = 9'h0;
    last = 1'b0;
    s_nxt = s_r;
    tbl_we = 1'b0;
    tbl_ch = 1'b0;
    tbl_idx = 11'h0;
    tbl_wvi = 32'h0;
    tbl_wt = 9'h0;

    // One second prescaler, shared by both channels
    if (s_r.pre == 27'(P_SEC_REPEAT_COUNT - 1)) begin
      s_nxt.pre = 27'h0;
      tick = 1'b1;
    end else begin
      s_nxt.pre = s_r.pre + 27'h1;
    end

    // Bus decode; ack drops the cycle after it is given
    acc = i_wb.cyc & i_wb.stb & ~s_r.ack;
    s_nxt.ack = acc;
    // Partial writes are ignored so a packed field never tears
    wr = acc & i_wb.we & (i_wb.sel == 4'hF);
    chs = i_wb.adr[`OSC_CH_STRIDE_BIT];
    rsel = i_wb.adr[4:2];
    wd = i_wb.dat;
    if (i_wb.adr[7:6] != 2'h0) begin
      rsel = 3'h7;
    end

    // Register read
    case (rsel)
      `OSC_REG_CFG: begin
        rd[`OSC_CFG_REC_EN] = s_r.ch[chs].rec_en;
        rd[`OSC_CFG_FIN_LAST] = s_r.ch[chs].fin_last;
        rd[`OSC_CFG_REP_INF] = s_r.ch[chs].rep_inf;
      end
      `OSC_REG_REPEAT: begin
        rd[15:0] = s_r.ch[chs].rep_cnt;
      end
      `OSC_REG_GROUPS: begin
        rd[11:0] = s_r.ch[chs].groups;
      end
      `OSC_REG_INDEX: begin
        rd[10:0] = s_r.ch[chs].idx_sel;
      end
      `OSC_REG_ENTRY_VI: begin
        rd = tbl_vi[chs][s_r.ch[chs].idx_sel];
      end
      `OSC_REG_ENTRY_T: begin
        rd[8:0] = tbl_t[chs][s_r.ch[chs].idx_sel];
      end
      `OSC_REG_STATUS: begin
        rd[`OSC_ST_RUN] = (s_r.ch[chs].seq == osc_pkg::SEQ_RUN);
        rd[`OSC_ST_DONE] = (s_r.ch[chs].seq == osc_pkg::SEQ_DONE);
        rd[`OSC_ST_OUT_EN] = s_r.ch[chs].out_en;
        rd[14:4] = s_r.ch[chs].step;
        rd[31:16] = s_r.ch[chs].cycle;
      end
      default: begin
        rd = 32'h0;
      end
    endcase
    s_nxt.rdat = acc ? rd : 32'h0;

    // Sequencer per channel
    for (int c = 0; c < 2; c++) begin
      if (tick && s_r.ch[c].seq == osc_pkg::SEQ_RUN) begin
        if (s_r.ch[c].dwell > `OSC_DWELL_MIN) begin
          s_nxt.ch[c].dwell = s_r.ch[c].dwell - 9'h1;
        end else begin
          last = ({1'b0, s_r.ch[c].step} + 12'h1 >= s_r.ch[c].groups);
          if (last && !s_r.ch[c].rep_inf &&
              ({1'b0, s_r.ch[c].cycle} + 17'h1 >= {1'b0, s_r.ch[c].rep_cnt})) begin
            // Stepping ends after groups times repeats steps
            s_nxt.ch[c].seq = osc_pkg::SEQ_DONE;
            s_nxt.ch[c].out_en = s_r.ch[c].fin_last;
          end else begin
            if (last) begin
              nidx = 11'h0;
              s_nxt.ch[c].cycle = s_r.ch[c].cycle + 16'h1;
            end else begin
              nidx = s_r.ch[c].step + 11'h1;
            end
            s_nxt.ch[c].step = nidx;
            t = tbl_t[c][nidx];
            s_nxt.ch[c].dwell = t;
            s_nxt.ch[c].volt = tbl_vi[c][nidx][15:0];
            s_nxt.ch[c].curr = tbl_vi[c][nidx][31:16];
          end
        end
      end
    end

    // Register write
    if (wr && rsel != 3'h7) begin
      case (rsel)
        `OSC_REG_CFG: begin
          s_nxt.ch[chs].rec_en = wd[`OSC_CFG_REC_EN];
          s_nxt.ch[chs].fin_last = wd[`OSC_CFG_FIN_LAST];
          s_nxt.ch[chs].rep_inf = wd[`OSC_CFG_REP_INF];
          if (wd[`OSC_CFG_STOP]) begin
            s_nxt.ch[chs].seq = osc_pkg::SEQ_IDLE;
            s_nxt.ch[chs].out_en = 1'b0;
          end else if (wd[`OSC_CFG_START]) begin
            // Start or restart from entry 0
            s_nxt.ch[chs].seq = osc_pkg::SEQ_RUN;
            s_nxt.ch[chs].out_en = 1'b1;
            s_nxt.ch[chs].step = 11'h0;
            s_nxt.ch[chs].cycle = 16'h0;
            s_nxt.ch[chs].dwell = tbl_t[chs][0];
            s_nxt.ch[chs].volt = tbl_vi[chs][0][15:0];
            s_nxt.ch[chs].curr = tbl_vi[chs][0][31:16];
          end
        end
        `OSC_REG_REPEAT: begin
          // Zero counts as a single pass
          s_nxt.ch[chs].rep_cnt = (wd[15:0] == 16'h0) ? `OSC_REPEAT_RST : wd[15:0];
        end
        `OSC_REG_GROUPS: begin
          // Out of range counts are refused, old value kept
          if (wd[31:0] >= 32'(`OSC_GROUPS_MIN) && wd[31:0] <= 32'(`OSC_GROUPS_MAX)) begin
            s_nxt.ch[chs].groups = wd[11:0];
          end
        end
        `OSC_REG_INDEX: begin
          s_nxt.ch[chs].idx_sel = wd[10:0];
        end
        `OSC_REG_ENTRY_VI: begin
          // Ranges of voltage and current are the host's duty
          s_nxt.ch[chs].vi_stage = wd;
        end
        `OSC_REG_ENTRY_T: begin
          // Dwell clamped so a bad time cannot stall or skip
          t = wd[8:0];
          if (wd[31:9] != 23'h0 || t > `OSC_DWELL_MAX) begin
            t = `OSC_DWELL_MAX;
          end else if (t < `OSC_DWELL_MIN) begin
            t = `OSC_DWELL_MIN;
          end
          tbl_we = 1'b1;
          tbl_ch = chs;
          tbl_idx = s_r.ch[chs].idx_sel;
          tbl_wvi = s_r.ch[chs].vi_stage;
          tbl_wt = t;
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r.ack <= 1'b0;
      s_r.rdat <= 32'h0;
      s_r.pre <= 27'h0;
      for (int c = 0; c < 2; c++) begin
        s_r.ch[c].rec_en <= 1'b0;
        s_r.ch[c].fin_last <= 1'b0;
        s_r.ch[c].rep_inf <= 1'b0;
        s_r.ch[c].rep_cnt <= `OSC_REPEAT_RST;
        s_r.ch[c].groups <= `OSC_GROUPS_RST;
        s_r.ch[c].idx_sel <= 11'h0;
        s_r.ch[c].vi_stage <= 32'h0;
        s_r.ch[c].seq <= osc_pkg::SEQ_IDLE;
        s_r.ch[c].out_en <= 1'b0;
        s_r.ch[c].step <= 11'h0;
        s_r.ch[c].cycle <= 16'h0;
        s_r.ch[c].dwell <= `OSC_DWELL_MIN;
        s_r.ch[c].volt <= 16'h0;
        s_r.ch[c].curr <= 16'h0;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign o_wb_ack = s_r.ack;
  assign o_wb_dat = s_r.rdat;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      o_supply[c].out_en = s_r.ch[c].out_en;
      o_supply[c].rec_en = s_r.ch[c].rec_en;
      o_supply[c].volt = s_r.ch[c].volt;
      o_supply[c].curr = s_r.ch[c].curr;
    end
  end

endmodule

// ===== test/osc_asserts.sv
// Bus and supply output checks for the output sequencer
`timescale 1ns/1ps
module osc_asserts #(
  parameter int unsigned P_SEC_REPEAT_COUNT = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Bus and supply
  input osc_pkg::wb_req_s i_wb,
  input logic [31:0] o_wb_dat,
  input logic o_wb_ack,
  input osc_pkg::supply_s [1:0] o_supply
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_req;
    i_wb.cyc && i_wb.stb && !o_wb_ack;
  endsequence
  sequence s_ack_once;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  // Output may settle one cycle after the ack
  sequence s_wr_near;
    (o_wb_ack && i_wb.we) || $past(o_wb_ack && i_wb.we);
  endsequence
  chk_ack_latency: assert property (s_req |=> s_ack_once)
    else $error("ack not one cycle after request");
  chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb.cyc && i_wb.stb))
    else $error("ack without request");
  chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  chk_rec_first: assert property ($changed(o_supply[0].rec_en) |-> s_wr_near)
    else $error("recorder flag moved without write");
  chk_rec_second: assert property ($changed(o_supply[1].rec_en) |-> s_wr_near)
    else $error("recorder flag moved without write");
  chk_start_cause: assert property ($rose(o_supply[0].out_en) |-> s_wr_near)
    else $error("output rose without write");
  chk_off_quiet: assert property (!o_supply[0].out_en && $past(!o_supply[0].out_en) && !o_wb_ack
    && !$past(o_wb_ack) |-> $stable(o_supply[0].volt))
    else $error("voltage moved while off");
  // Dwell of one second must be at least nine clocks here
  chk_dwell_hold: assert property ($changed(o_supply[0].volt) && $past(o_supply[0].out_en)
    && !o_wb_ack && !$past(o_wb_ack) |=> ($stable(o_supply[0].volt) || !o_supply[0].out_en) [*8])
    else $error("entry shorter than a dwell tick");
endmodule

bind osc_top osc_asserts #(.P_SEC_REPEAT_COUNT(P_SEC_REPEAT_COUNT)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_wb(i_wb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_supply(o_supply));

// ===== test/osc_host.sv
// Host model issuing classic Wishbone set-up repeat_count
`timescale 1ns/1ps
`include "osc_map.svh"
module osc_host (
  // Bus return
  input wire logic i_clk,
  input wire logic [31:0] i_dat,
  input wire logic i_ack,
  // Bus request
  output osc_pkg::wb_req_s o_wb
);
  // ==========================================================
  // Bus repeat_count
  initial o_wb = '0;
  task automatic xfer(input logic we, input logic ch, input logic [2:0] r, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk);
    o_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {2'b00, ch, r, 2'b00}, sel: 4'hF, dat: d};
    do @(posedge i_clk); while (i_ack !== 1'b1);
    q = i_dat;
    o_wb <= '0;
  endtask
  task automatic wr(input logic ch, input logic [2:0] r, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, ch, r, d, q);
  endtask
  // Table entry; codes are taken as already range checked
  task automatic entry(input logic ch, input logic [10:0] idx, input logic [15:0] v,
                       input logic [15:0] c, input logic [8:0] t);
    wr(ch, `OSC_REG_INDEX, {21'h0, idx});
    wr(ch, `OSC_REG_ENTRY_VI, {c, v});
    wr(ch, `OSC_REG_ENTRY_T, {23'h0, t});
  endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the output sequencer
`timescale 1ns/1ps
`include "osc_map.svh"
module tb;
  localparam int P_SEC = 10;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  osc_pkg::wb_req_s i_wb;
  osc_pkg::supply_s [1:0] o_supply;
  int fail_count = 0;
  int checks = 0;
  int cyc_n = 0;
  always #4 i_clk = ~i_clk;
  osc_top #(.P_SEC_REPEAT_COUNT(P_SEC)) uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb(i_wb),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_supply(o_supply));
  osc_host host (.i_clk(i_clk), .i_dat(o_wb_dat), .i_ack(o_wb_ack), .o_wb(i_wb));
  // ==========================================================
  // Helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic ch, input logic [2:0] r, input logic [31:0] exp);
    logic [31:0] q;
    host.xfer(1'b0, ch, r, 32'h0, q);
    cmp(q, exp);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rdc(1'b0, `OSC_REG_GROUPS, 32'h1);
    host.wr(1'b1, `OSC_REG_CFG, 32'h7);
    rdc(1'b1, `OSC_REG_CFG, 32'h7);
    cmp({o_supply[1].rec_en, o_supply[0].rec_en}, 32'h2);
    host.wr(1'b1, `OSC_REG_CFG, 32'h0);
    rdc(1'b1, `OSC_REG_CFG, 32'h0);
    host.wr(1'b0, `OSC_REG_GROUPS, 32'h800);
    host.wr(1'b0, `OSC_REG_GROUPS, 32'h0);
    host.wr(1'b0, `OSC_REG_GROUPS, 32'h801);
    rdc(1'b0, `OSC_REG_GROUPS, 32'h800);
    host.wr(1'b0, 3'h7, 32'hFFFF);
    rdc(1'b0, 3'h7, 32'h0);
    host.wr(1'b1, `OSC_REG_REPEAT, 32'h14);
    rdc(1'b1, `OSC_REG_REPEAT, 32'h14);
    $display("test regs done");
  endtask
  // Three entries, two repeat_count; the first dwell may be cut short
  task automatic t_seq(input logic fin);
    logic [15:0] seen [$];
    int tm [$];
    int t_off;
    t_off = 0;
    for (int i = 0; i < 3; i++) host.entry(1'b0, 11'(i), 16'(256 + i), 16'(512 + i), 9'(i + 1));
    host.wr(1'b0, `OSC_REG_GROUPS, 32'h3);
    host.wr(1'b0, `OSC_REG_REPEAT, 32'h2);
    host.wr(1'b0, `OSC_REG_CFG, {28'h0, 2'b10, fin, 1'b0});
    for (int c = 1; c < 160; c++) begin
      @(negedge i_clk);
      if (o_supply[0].out_en === 1'b1 && (seen.size() == 0 || o_supply[0].volt !== seen[$])) begin
        seen.push_back(o_supply[0].volt);
        tm.push_back(c);
      end
      if (o_supply[0].out_en === 1'b0 && seen.size() > 0 && t_off == 0) t_off = c;
    end
    cmp(32'(seen.size()), 32'h6);
    foreach (seen[k]) cmp({16'h0, seen[k]}, 32'(256 + k % 3));
    if (seen.size() == 6) begin
      for (int k = 1; k < 5; k++) cmp(32'(tm[k + 1] - tm[k]), 32'(P_SEC * (k % 3 + 1)));
      if (!fin) cmp(32'(t_off - tm[5]), 32'(P_SEC * 3));
    end
    cmp({31'h0, o_supply[0].out_en}, {31'h0, fin});
    if (fin) cmp({o_supply[0].curr, o_supply[0].volt}, 32'h0202_0102);
    // Done on entry 2 of pass 1; output bit follows finish behaviour
    rdc(1'b0, `OSC_REG_STATUS, fin ? 32'h0001_0026 : 32'h0001_0022);
    rdc(1'b0, `OSC_REG_ENTRY_VI, 32'h0202_0102);
    rdc(1'b0, `OSC_REG_ENTRY_T, 32'h3);
    $display("test seq done");
  endtask
  task automatic t_inf();
    host.entry(1'b1, 11'h0, 16'h0300, 16'h0400, 9'h001);
    host.wr(1'b1, `OSC_REG_GROUPS, 32'h1);
    host.wr(1'b1, `OSC_REG_CFG, 32'hC);
    repeat (300) @(negedge i_clk);
    cmp({31'h0, o_supply[1].out_en}, 32'h1);
    cmp({o_supply[1].curr, o_supply[1].volt}, 32'h0400_0300);
    host.wr(1'b1, `OSC_REG_CFG, 32'h10);
    repeat (2) @(negedge i_clk);
    cmp({31'h0, o_supply[1].out_en}, 32'h0);
    $display("test inf done");
  endtask
  // ==========================================================
  // Run control
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs();
    t_seq(1'b0);
    t_seq(1'b1);
    t_inf();
    summarize();
  end
endmodule
